// file: positioning_error_detect_defs.vh
// Constants for the positioning error detection block.
`ifndef POSITIONING_ERROR_DETECT_DEFS_VH
`define POSITIONING_ERROR_DETECT_DEFS_VH
`define PED_MODE_W 2
`define PED_MODE_NO_PROX 2'h0
`define PED_DEV_W 16
`define PED_DWELL_W 16
`define PED_STATE_W 4
`define PED_ST_IDLE 4'h1
`define PED_ST_MOVE 4'h2
`define PED_ST_SEARCH 4'h4
`define PED_ST_SETTLE 4'h8
`define PED_PIN_N 3
`define PED_PIN_PROX 0
`define PED_PIN_ORIGIN 1
`define PED_PIN_LIMIT 2
`endif

// file: dwell_timer.v
// Completion dwell timer: counts a programmed number of cycles after a start pulse.
`timescale 1ns/1ps
`default_nettype none
`include "positioning_error_detect_defs.vh"
module dwell_timer #(
  parameter W = `PED_DWELL_W
) (
  // Clock and reset
  input wire sys_clk,
  input wire rst,
  // Control
  input wire start,
  input wire abort,
  input wire [W-1:0] length,
  // Result
  output reg done
);
  reg [W-1:0] count;
  reg running;
  // ========================================
  // Counter
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      count <= {W{1'b0}};
      running <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (abort)
      begin
        running <= 1'b0;
      end
      else if (start)
      begin
        count <= length;
        running <= (length != {W{1'b0}});
        done <= (length == {W{1'b0}});
      end
      else if (running)
      begin
        if (count == {{(W-1){1'b0}}, 1'b1})
        begin
          running <= 1'b0;
          done <= 1'b1;
        end
        count <= count - {{(W-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule // dwell_timer
`default_nettype wire

// file: positioning_error_detect.v
// Position control unit error detection and completion handshake.
`timescale 1ns/1ps
`default_nettype none
`include "positioning_error_detect_defs.vh"
module positioning_error_detect #(
  parameter DEV_W = `PED_DEV_W,
  parameter DWELL_W = `PED_DWELL_W
) (
  // Clock and reset
  input wire sys_clk,
  input wire rst,
  // Controller commands
  input wire cmd_move,
  input wire cmd_search,
  input wire cmd_other,
  input wire cmd_stop,
  input wire err_clear,
  // Configuration
  input wire [`PED_MODE_W-1:0] search_mode,
  input wire use_prox,
  input wire [DEV_W-1:0] complete_width,
  input wire [DWELL_W-1:0] dwell_length,
  // Motion engine
  input wire motion_done,
  input wire signed [DEV_W-1:0] deviation,
  // Servo-side pins
  input wire prox_pin,
  input wire origin_pin,
  input wire limit_pin,
  // Status
  output wire busy,
  output wire ready,
  output reg pos_complete,
  output reg err_cmd_timing,
  output reg err_no_prox,
  output reg err_no_origin
);
  // ========================================
  // State codes and pin order
  localparam [`PED_STATE_W-1:0] ST_IDLE = `PED_ST_IDLE;
  localparam [`PED_STATE_W-1:0] ST_MOVE = `PED_ST_MOVE;
  localparam [`PED_STATE_W-1:0] ST_SEARCH = `PED_ST_SEARCH;
  localparam [`PED_STATE_W-1:0] ST_SETTLE = `PED_ST_SETTLE;
  localparam PIN_N = `PED_PIN_N;
  wire [PIN_N-1:0] pin_raw;
  wire [PIN_N-1:0] pin_sync;
  reg [`PED_STATE_W-1:0] state;
  reg [`PED_STATE_W-1:0] next_state;
  reg prox_seen;
  wire prox_now;
  wire origin_now;
  wire limit_now;
  wire need_prox;
  wire [DEV_W-1:0] abs_dev;
  wire in_width;
  wire new_cmd;
  wire dwell_done;
  wire settle_start;
  genvar gi;
  // ========================================
  // Pin synchronisers
  // The first stage may go metastable, so only the second stage reads it.
  assign pin_raw[`PED_PIN_PROX] = prox_pin;
  assign pin_raw[`PED_PIN_ORIGIN] = origin_pin;
  assign pin_raw[`PED_PIN_LIMIT] = limit_pin;
  generate
    for (gi = 0; gi < PIN_N; gi = gi + 1)
    begin : g_sync
      reg meta;
      reg stable;
      always @(posedge sys_clk or posedge rst)
      begin
        if (rst)
        begin
          meta <= 1'b0;
          stable <= 1'b0;
        end
        else
        begin
          meta <= pin_raw[gi];
          stable <= meta;
        end
      end
      assign pin_sync[gi] = stable;
    end
  endgenerate
  assign prox_now = pin_sync[`PED_PIN_PROX];
  assign origin_now = pin_sync[`PED_PIN_ORIGIN];
  assign limit_now = pin_sync[`PED_PIN_LIMIT];
  // ========================================
  // Decode
  // Mode 0 only skips proximity when configured off; other modes force it.
  assign need_prox = (search_mode != `PED_MODE_NO_PROX) | use_prox;
  assign abs_dev = deviation[DEV_W-1] ? (~deviation + {{(DEV_W-1){1'b0}}, 1'b1}) : deviation;
  assign in_width = (abs_dev <= complete_width);
  assign new_cmd = cmd_move | cmd_search | cmd_other;
  assign busy = (state != ST_IDLE);
  // The host is expected to poll ready before commanding; no queue exists behind it.
  assign ready = ~busy;
  assign settle_start = (state == ST_MOVE) & motion_done & in_width;
  // ========================================
  // Sequencer
  always @*
  begin
    next_state = state;
    case (state)
      ST_IDLE:
      begin
        if (cmd_search)
        begin
          next_state = ST_SEARCH;
        end
        else if (cmd_move)
        begin
          next_state = ST_MOVE;
        end
      end
      ST_MOVE:
      begin
        if (cmd_stop)
        begin
          next_state = ST_IDLE;
        end
        else if (settle_start)
        begin
          next_state = ST_SETTLE;
        end
      end
      ST_SEARCH:
      begin
        // A limit hit with the origin signal on ends the search as a failure.
        if (cmd_stop | motion_done | (origin_now & limit_now))
        begin
          next_state = ST_IDLE;
        end
      end
      ST_SETTLE:
      begin
        // Next step waits until completion has been confirmed.
        if (cmd_stop | dwell_done)
        begin
          next_state = ST_IDLE;
        end
      end
      default:
      begin
        next_state = ST_IDLE;
      end
    endcase
  end
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state <= ST_IDLE;
    end
    else
    begin
      state <= next_state;
    end
  end
  // ========================================
  // Error flags: an event in the clearing cycle wins over the clear.
  // The sighting is rearmed in idle so that an earlier search cannot hide a dead sensor.
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      prox_seen <= 1'b0;
    end
    else if (state == ST_IDLE)
    begin
      prox_seen <= 1'b0;
    end
    else if (state == ST_SEARCH && prox_now)
    begin
      prox_seen <= 1'b1;
    end
  end
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      err_cmd_timing <= 1'b0;
    end
    else if (busy && new_cmd)
    begin
      err_cmd_timing <= 1'b1;
    end
    else if (err_clear)
    begin
      err_cmd_timing <= 1'b0;
    end
  end
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      err_no_prox <= 1'b0;
    end
    else if (state == ST_SEARCH && need_prox && !prox_seen && !prox_now && (motion_done | limit_now))
    begin
      err_no_prox <= 1'b1;
    end
    else if (err_clear)
    begin
      err_no_prox <= 1'b0;
    end
  end
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      err_no_origin <= 1'b0;
    end
    else if (state == ST_SEARCH && origin_now && limit_now)
    begin
      err_no_origin <= 1'b1;
    end
    else if (err_clear)
    begin
      err_no_origin <= 1'b0;
    end
  end
  // ========================================
  // Completion output: level from dwell expiry until the next command.
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      pos_complete <= 1'b0;
    end
    else if (new_cmd && !busy)
    begin
      pos_complete <= 1'b0;
    end
    else if (dwell_done && state == ST_SETTLE)
    begin
      pos_complete <= 1'b1;
    end
  end
  dwell_timer #(
    .W(DWELL_W)
  ) u_dwell (
    .sys_clk(sys_clk),
    .rst(rst),
    .start(settle_start),
    .abort(cmd_stop),
    .length(dwell_length),
    .done(dwell_done)
  );
endmodule // positioning_error_detect
`default_nettype wire

// file: ped_asserts.sv
// Checker for the positioning error detector.
`timescale 1ns/1ps
`default_nettype none
module ped_asserts #(parameter DEV_W = 16, DWELL_W = 16) (
  // Inputs and status.
  input wire logic sys_clk, rst, cmd_move, cmd_search, cmd_other, cmd_stop, use_prox, motion_done,
  input wire logic origin_pin, limit_pin, busy, pos_complete, err_cmd_timing, err_no_prox, err_no_origin,
  input wire logic [1:0] search_mode,
  input wire logic [DEV_W-1:0] complete_width,
  input wire logic signed [DEV_W-1:0] deviation,
  input wire logic [DWELL_W-1:0] dwell_length
);
  logic srch;
  wire cmd = cmd_move | cmd_search | cmd_other;
  wire [DEV_W-1:0] adev = deviation < 0 ? -deviation : deviation;
  wire fit = busy && !srch && motion_done && !cmd_stop;
  // Search is only known at the port from the command that started the busy spell.
  always_ff @(posedge sys_clk or posedge rst)
    if (rst) srch <= 1'h0;
    else if (!busy) srch <= cmd_search;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_hit; (srch && busy && origin_pin && limit_pin) [*3]; endsequence
  property p_cmd; busy && cmd && !cmd_stop |=> err_cmd_timing; endproperty
  a_cmd: assert property (p_cmd) else $error("busy command not flagged");
  property p_start; !busy && cmd_move && !cmd_stop |=> busy; endproperty
  a_start: assert property (p_start) else $error("move not taken");
  property p_done; $rose(pos_complete) |-> !busy; endproperty
  a_done: assert property (p_done) else $error("complete while busy");
  property p_hold; pos_complete && !cmd && !cmd_stop |=> pos_complete; endproperty
  a_hold: assert property (p_hold) else $error("complete dropped");
  sequence s_dwell; !pos_complete [*4] ##[1:2] pos_complete; endsequence
  property p_fin; fit && adev <= complete_width && dwell_length == 3 |=> s_dwell; endproperty
  a_fin: assert property (p_fin) else $error("dwell timing wrong");
  property p_wide; fit && adev > complete_width |=> !pos_complete [*6]; endproperty
  a_wide: assert property (p_wide) else $error("complete outside width");
  property p_prox; $rose(err_no_prox) |-> $past(busy) && (search_mode != 2'h0 || use_prox); endproperty
  a_prox: assert property (p_prox) else $error("proximity error unexpected");
  property p_orig; s_hit |=> ##[0:1] err_no_origin; endproperty
  a_orig: assert property (p_orig) else $error("origin error missing");
  property p_stop; busy && cmd_stop |=> !busy; endproperty
  a_stop: assert property (p_stop) else $error("stop not taken");
endmodule // ped_asserts
`default_nettype wire

// file: ped_host.sv
// Host controller model that starts moves and watches completion.
`timescale 1ns/1ps
`default_nettype none
module ped_host (
  input wire logic sys_clk, rst, go, ready, pos_complete,
  output logic cmd_move, step_done
);
  logic pend, last;
  always_ff @(posedge sys_clk or posedge rst)
    if (rst)
    begin
      {pend, cmd_move, step_done, last} <= 4'h0;
    end
    else
    begin
      last <= pos_complete;
      step_done <= pos_complete && !last;
      // A request waits for status rather than firing blind.
      cmd_move <= (pend || go) && ready && !cmd_move;
      pend <= (pend || go) && !(ready && !cmd_move);
    end
endmodule // ped_host
`default_nettype wire

// file: positioning_error_detect_tb.sv
// Testbench for the positioning error detector.
`timescale 1ns/1ps
`default_nettype none
module positioning_error_detect_tb;
  logic sys_clk = 1'h0, rst = 1'h1, go = 1'h0, use_prox = 1'h0, prox_pin = 1'h0, origin_pin = 1'h0, limit_pin = 1'h0;
  logic [4:0] pl = 5'h00;
  logic [1:0] search_mode = 2'h0;
  logic [15:0] complete_width = 16'h0010, dwell_length = 16'h0003;
  logic signed [15:0] deviation = 16'h0000;
  logic [3:0] q[$], last = 4'h0, ev;
  int fails = 0, tests_run = 0, steps = 0, i;
  wire cmd_move, step_done, busy, ready, pos_complete, err_cmd_timing, err_no_prox, err_no_origin;
  wire cmd_search = pl[4], cmd_other = pl[3], cmd_stop = pl[2], err_clear = pl[1], motion_done = pl[0];
  always #2.5 sys_clk = ~sys_clk;
  positioning_error_detect dut (.*);
  ped_host host (.*);
  task chk(input string n, input logic [3:0] e, s);
    tests_run++;
    if (e !== s)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task close_out(input int t);
    fails += t;
    $display("tests_run=%0d fails=%0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task pulse(input logic [4:0] v);
    pl <= v;
    @(posedge sys_clk);
    pl <= 5'h00;
    @(posedge sys_clk);
  endtask
  task hold(input logic b);
    for (i = 0; i < 99 && (b ? busy !== 1'h1 : q.size() > 0); i++)
      @(posedge sys_clk);
    if (i == 99)
      close_out(1);
  endtask
  // Only rising status bits are results; falls come from clears and new commands.
  always @(posedge sys_clk)
  begin
    ev = {pos_complete, err_cmd_timing, err_no_prox, err_no_origin};
    if ((ev & ~last) != 4'h0)
      chk("status", q.size() > 0 ? q.pop_front() : 4'hx, ev);
    last = ev;
  end
  always @(posedge sys_clk) steps += (step_done === 1'h1);
  initial
  begin
    void'($urandom(32'h78879a28));
    repeat (10) @(posedge sys_clk);
    chk("ready", 4'h1, {3'h0, ready});
    rst <= 1'h0;
    go <= 1'h1;
    @(posedge sys_clk);
    go <= 1'h0;
    hold(1);
    q.push_back(4'h4);
    pulse(5'h08);
    pulse(5'h0a);
    chk("set_wins", 4'h1, {3'h0, err_cmd_timing});
    deviation <= 16'h0100;
    pulse(5'h01);
    repeat (3) @(posedge sys_clk);
    chk("busy", 4'h1, {3'h0, busy});
    deviation <= 16'($urandom_range(32)) - 16'h0010;
    q.push_back(4'hc);
    pulse(5'h01);
    hold(0);
    pulse(5'h02);
    chk("steps", 4'h1, steps[3:0]);
    go <= 1'h1;
    @(posedge sys_clk);
    go <= 1'h0;
    hold(1);
    chk("ready", 4'h0, {3'h0, ready});
    pulse(5'h04);
    chk("busy", 4'h0, {3'h0, busy});
    for (int m = 0; m < 5; m++)
    begin
      search_mode <= m[1:0];
      use_prox <= m == 4;
      if (m > 0) q.push_back(4'h2);
      pulse(5'h10);
      pulse(5'h01);
      hold(0);
      pulse(5'h04);
      pulse(5'h02);
    end
    search_mode <= 2'h1;
    pulse(5'h10);
    prox_pin <= 1'h1;
    repeat (4) @(posedge sys_clk);
    prox_pin <= 1'h0;
    pulse(5'h01);
    chk("no_prox", 4'h0, {3'h0, err_no_prox});
    search_mode <= 2'h0;
    use_prox <= 1'h0;
    q.push_back(4'h1);
    pulse(5'h10);
    {origin_pin, limit_pin} <= 2'h3;
    repeat (4) @(posedge sys_clk);
    {origin_pin, limit_pin} <= 2'h0;
    hold(0);
    close_out(0);
  end
endmodule // positioning_error_detect_tb
bind positioning_error_detect ped_asserts #(.DEV_W(DEV_W), .DWELL_W(DWELL_W)) ped_chk (
  .sys_clk(sys_clk), .rst(rst), .cmd_move(cmd_move), .cmd_search(cmd_search), .cmd_other(cmd_other),
  .cmd_stop(cmd_stop), .use_prox(use_prox), .motion_done(motion_done), .origin_pin(origin_pin),
  .limit_pin(limit_pin), .busy(busy), .pos_complete(pos_complete), .err_cmd_timing(err_cmd_timing),
  .err_no_prox(err_no_prox), .err_no_origin(err_no_origin), .search_mode(search_mode),
  .complete_width(complete_width), .deviation(deviation), .dwell_length(dwell_length)
);
`default_nettype wire
